/* File: verilog/ltc_pkg.sv */
// ltc_pkg: constants and types for the transmit lane capture block.
// assumes: imported by every lane capture file; holds no logic.
package ltc_pkg;

  // lane pairs handled here: c/d, e/f, g/h
  localparam int N_PAIRS = 3;
  // bits carried by one lane: eight data, bit 8, bit 9
  localparam int LANE_W = 10;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 10;
  // nibble mode lane split
  localparam int NIB_W = 5;
  localparam int NIB_LO_TOP = 4;
  localparam int NIB_HI_BOT = 5;
  localparam int NIB_HI_TOP = 9;
  // data nibble width when the encoder is on
  localparam int KNIB_W = 4;
  // k flag positions on the lane
  localparam int BIT_K_LO = 3;
  localparam int BIT_K_HI = 8;
  localparam int BIT_NINE = 8;
  // one fifo word: {k_hi, word_hi, k_lo, word_lo}
  localparam int PKT_W = 2 * WORD_W + 2;
  localparam int FIFO_DEPTH = 4;

  // reset values
  localparam logic [LANE_W-1:0] LANE_RST = 10'h000;
  localparam logic [1:0] SYNC_RST = 2'h0;

  // parallel interface modes
  typedef enum logic [1:0] {
    LTC_MODE_MUX,
    LTC_MODE_NIBBLE,
    LTC_MODE_INDEP
  } ltc_mode_t;

endpackage

/* File: verilog/ltc_capture.sv */
// ltc_capture: ddr capture of the c/d, e/f and g/h transmit lanes,
// reassembly into per-channel words and crossing to the system clock.
// assumes: mode and encoder straps are static while the link clocks run;
// the far side drives lanes centred on both edges of the lane clock.
//
// Function
// - lanes are taken on both clock edges; bit 0 goes out first
// - multiplexed: upper channel on rising edge, lower on falling edge
// - nibble: low nibble on falling edge, high nibble on next rising
// - nibble: lower channel on lane bits 4..0, upper on bits 9..5
// - multiplexed, no encoder: lane bit 8 is word bit 8
// - multiplexed, encoder on: bit 8 flags the byte as k-character
// - encoder off, outside nibble mode: lane bit 9 is word bit 9
// - nibble, no encoder: bit 8 gives upper word bits 3 and 8
// - nibble, encoder on: bit 8 is upper channel k flag
// - nibble, encoder on: bit 3 is lower channel k flag
// - independent mode: each pair runs on its own pair clock
// - other modes: every pair runs on the shared transmit clock
// - outside independent mode, shared clock latches all pairs on both its edges
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// dual clock fifo with gray pointers; depth must be a power of two,
// four or more, since the full test flips the top two gray bits and
// the pins on the write side cannot be stalled by it
module ltc_afifo #(
  parameter int W = 22,
  parameter int DEPTH = 4
) (
  input wire logic wr_clk_i,
  input wire logic wr_rst_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [W-1:0] wr_data_i,
  input wire logic rd_clk_i,
  input wire logic rd_rst_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [W-1:0] rd_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wbin;
  logic [AW:0] wgray;
  logic [AW:0] rbin;
  logic [AW:0] rgray;
  logic [AW:0] rg_m;
  logic [AW:0] rg_s;
  logic [AW:0] rg_t;
  logic [AW:0] rg_q;
  logic [AW:0] wg_m;
  logic [AW:0] wg_s;
  logic [AW:0] wg_t;
  logic [AW:0] wg_q;
  logic [AW:0] next_wbin;
  logic [AW:0] next_rbin;
  logic wr_go;
  logic rd_go;

  // full compares against the read pointer one lap behind
  assign wr_ready_o = (wgray != {~rg_q[AW:AW-1], rg_q[AW-2:0]});
  // empty once the read pointer has caught the accepted write pointer
  assign rd_valid_o = (rgray != wg_q);
  assign wr_go = wr_valid_i && wr_ready_o;
  assign rd_go = rd_valid_o && rd_ready_i;
  assign next_wbin = wbin + (AW+1)'(1);
  assign next_rbin = rbin + (AW+1)'(1);
  // storage read directly: the word stands until it is popped
  assign rd_data_o = mem[rbin[AW-1:0]];

  // storage, written on the write clock only
  always_ff @(posedge wr_clk_i) begin
    if (wr_go) begin
      mem[wbin[AW-1:0]] <= wr_data_i;
    end
  end

  // write pointer
  always_ff @(posedge wr_clk_i) begin
    if (wr_rst_i) begin
      wbin <= '0;
      wgray <= '0;
    end else if (wr_go) begin
      wbin <= next_wbin;
      wgray <= next_wbin ^ (next_wbin >> 1);
    end
  end

  // read pointer into the write side through three stages; a value
  // counts once the last two agree, so a pointer caught mid-change
  // never reaches the full test
  always_ff @(posedge wr_clk_i) begin
    if (wr_rst_i) begin
      rg_m <= '0;
      rg_s <= '0;
      rg_t <= '0;
    end else begin
      rg_m <= rgray;
      rg_s <= rg_m;
      rg_t <= rg_s;
    end
  end

  // accepted read pointer; while reads run back to back it may lag,
  // which only makes the full flag cautious
  always_ff @(posedge wr_clk_i) begin
    if (wr_rst_i) begin
      rg_q <= '0;
    end else if (rg_s == rg_t) begin
      rg_q <= rg_t;
    end
  end

  // read pointer
  always_ff @(posedge rd_clk_i) begin
    if (rd_rst_i) begin
      rbin <= '0;
      rgray <= '0;
    end else if (rd_go) begin
      rbin <= next_rbin;
      rgray <= next_rbin ^ (next_rbin >> 1);
    end
  end

  // write pointer into the read side, same three stages
  always_ff @(posedge rd_clk_i) begin
    if (rd_rst_i) begin
      wg_m <= '0;
      wg_s <= '0;
      wg_t <= '0;
    end else begin
      wg_m <= wgray;
      wg_s <= wg_m;
      wg_t <= wg_s;
    end
  end

  // accepted write pointer; a word shows some four read clocks late
  always_ff @(posedge rd_clk_i) begin
    if (rd_rst_i) begin
      wg_q <= '0;
    end else if (wg_s == wg_t) begin
      wg_q <= wg_t;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
// lane capture top
module ltc_capture #(
  parameter int NP = ltc_pkg::N_PAIRS,
  parameter int DEPTH = ltc_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire ltc_pkg::ltc_mode_t mode_i,
  input wire logic encode_en_i,
  input wire logic shared_tx_clock_i,
  input wire logic tx_clock_pair_cd_i,
  input wire logic tx_clock_pair_ef_i,
  input wire logic tx_clock_pair_gh_i,
  input wire logic [7:0] tx_lane_cd_i,
  input wire logic tx_lane_cd_bit8_kflag_i,
  input wire logic tx_lane_cd_bit9_i,
  input wire logic [7:0] tx_lane_ef_i,
  input wire logic tx_lane_ef_bit8_kflag_i,
  input wire logic tx_lane_ef_bit9_i,
  input wire logic [7:0] tx_lane_gh_i,
  input wire logic tx_lane_gh_bit8_kflag_i,
  input wire logic tx_lane_gh_bit9_i,
  output logic [NP-1:0] capture_ready_o,
  output logic [NP-1:0] word_valid_o,
  input wire logic [NP-1:0] word_ready_i,
  output logic [NP-1:0][ltc_pkg::WORD_W-1:0] word_lo_o,
  output logic [NP-1:0] k_lo_o,
  output logic [NP-1:0][ltc_pkg::WORD_W-1:0] word_hi_o,
  output logic [NP-1:0] k_hi_o
);
  import ltc_pkg::*;

  logic [NP-1:0][LANE_W-1:0] lane;
  logic [NP-1:0] pair_clk;

  // gather each pair's pins into one lane; bit 3 rides in the byte
  assign lane[0] = {tx_lane_cd_bit9_i, tx_lane_cd_bit8_kflag_i,
                    tx_lane_cd_i};
  assign lane[1] = {tx_lane_ef_bit9_i, tx_lane_ef_bit8_kflag_i,
                    tx_lane_ef_i};
  assign lane[2] = {tx_lane_gh_bit9_i, tx_lane_gh_bit8_kflag_i,
                    tx_lane_gh_i};
  assign pair_clk = {tx_clock_pair_gh_i, tx_clock_pair_ef_i,
                     tx_clock_pair_cd_i};

  // every pair owns its clock pick, synchronisers and fifo, so one
  // pair whose clock stops never holds up the others
  for (genvar p = 0; p < NP; p++) begin : g_pair
    logic lclk;
    logic rs_m;
    logic rs_p;
    logic rs_t;
    logic lrst;
    logic [1:0] md_m;
    logic [1:0] md_p;
    logic [1:0] md_t;
    logic [1:0] md_s;
    logic en_m;
    logic en_p;
    logic en_t;
    logic en_s;
    logic [LANE_W-1:0] fall;
    logic fall_ok;
    logic [WORD_W-1:0] next_lo;
    logic [WORD_W-1:0] next_hi;
    logic next_klo;
    logic next_khi;
    logic [PKT_W-1:0] rd_pkt;

    // clock pick is a plain mux: the strap must not move while the
    // link clocks run, or the pair sees a runt edge
    assign lclk = (mode_i == LTC_MODE_INDEP) ? pair_clk[p]
                                             : shared_tx_clock_i;

    // system reset into the lane domain through three stages
    always_ff @(posedge lclk) begin
      rs_m <= rst_i;
      rs_p <= rs_m;
      rs_t <= rs_p;
    end

    // the lane reset moves once the last two stages agree; this costs
    // four lane edges each way, so reset must span more than that
    always_ff @(posedge lclk) begin
      if (rs_p == rs_t) begin
        lrst <= rs_t;
      end
    end

    // mode strap through three stages; left out of reset so that its
    // level has settled by the time the lane reset lets go
    always_ff @(posedge lclk) begin
      md_m <= mode_i;
      md_p <= md_m;
      md_t <= md_p;
    end

    // the mode counts once the last two stages agree
    always_ff @(posedge lclk) begin
      if (md_p == md_t) begin
        md_s <= md_t;
      end
    end

    // encoder strap, same three stages and no reset
    always_ff @(posedge lclk) begin
      en_m <= encode_en_i;
      en_p <= en_m;
      en_t <= en_p;
    end

    // the encoder strap counts once the last two stages agree
    always_ff @(posedge lclk) begin
      if (en_p == en_t) begin
        en_s <= en_t;
      end
    end

    // falling edge half of the pair; the rising half is read live, so
    // the lanes must still stand at the rising edge
    always_ff @(negedge lclk) begin
      if (lrst) begin
        fall <= LANE_RST;
        fall_ok <= 1'b0;
      end else begin
        fall <= lane[p];
        fall_ok <= 1'b1;
      end
    end

    // join the falling sample with the live rising edge lanes; every
    // field not used by the format stays zero
    always_comb begin
      next_lo = '0;
      next_hi = '0;
      next_klo = 1'b0;
      next_khi = 1'b0;
      if (md_s == LTC_MODE_NIBBLE) begin
        if (en_s) begin
          // flag taken from the nibble's top bit on the rising edge
          next_lo[BYTE_W-1:0] = {lane[p][KNIB_W-1:0],
                                 fall[KNIB_W-1:0]};
          next_klo = lane[p][BIT_K_LO];
          next_hi[BYTE_W-1:0] = {lane[p][BIT_K_HI:NIB_HI_BOT],
                                 fall[BIT_K_HI:NIB_HI_BOT]};
          next_khi = lane[p][BIT_K_HI];
        end else begin
          next_lo = {lane[p][NIB_LO_TOP:0],
                     fall[NIB_LO_TOP:0]};
          // bit 8 lands on word bits 3 and 8
          next_hi = {lane[p][NIB_HI_TOP:NIB_HI_BOT],
                     fall[NIB_HI_TOP:NIB_HI_BOT]};
        end
      end else begin
        if (en_s) begin
          // bit 9 is ignored here, whatever the far side drives
          next_lo[BYTE_W-1:0] = fall[BYTE_W-1:0];
          next_klo = fall[BIT_K_HI];
          next_hi[BYTE_W-1:0] = lane[p][BYTE_W-1:0];
          next_khi = lane[p][BIT_K_HI];
        end else begin
          // bit 8 and bit 9 pass straight into the word
          next_lo = fall;
          next_hi = lane[p];
        end
      end
    end

    // one word per channel on every rising edge that closes a pair;
    // the pins cannot stall, so a full fifo drops the pair
    ltc_afifo #(
      .W(PKT_W),
      .DEPTH(DEPTH)
    ) u_fifo (
      .wr_clk_i(lclk),
      .wr_rst_i(lrst),
      .wr_valid_i(fall_ok),
      .wr_ready_o(capture_ready_o[p]),
      .wr_data_i({next_khi, next_hi, next_klo, next_lo}),
      .rd_clk_i(clk_sys_i),
      .rd_rst_i(rst_i),
      .rd_valid_o(word_valid_o[p]),
      .rd_ready_i(word_ready_i[p]),
      .rd_data_o(rd_pkt)
    );

    // unpack, word bit 0 is serialised first
    assign word_lo_o[p] = rd_pkt[WORD_W-1:0];
    assign k_lo_o[p] = rd_pkt[WORD_W];
    assign word_hi_o[p] = rd_pkt[PKT_W-2:WORD_W+1];
    assign k_hi_o[p] = rd_pkt[PKT_W-1];
  end
endmodule

/* File: dv/ltc_capture_asserts.sv */
// ltc_capture_asserts: port checks on the lane capture block.
// assumes: bound to ltc_capture; watches the system clock side only.
`timescale 1ns/1ps
module ltc_capture_chk #(
  parameter int NP = 3
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire ltc_pkg::ltc_mode_t mode_i,
  input wire logic encode_en_i,
  input wire logic [NP-1:0] word_valid_o,
  input wire logic [NP-1:0] word_ready_i,
  input wire logic [NP-1:0][ltc_pkg::WORD_W-1:0] word_lo_o,
  input wire logic [NP-1:0] k_lo_o,
  input wire logic [NP-1:0][ltc_pkg::WORD_W-1:0] word_hi_o,
  input wire logic [NP-1:0] k_hi_o
);
  import ltc_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic nib_enc;
  logic mux_enc;
  // strap decode; straps only move under reset
  assign nib_enc = encode_en_i && mode_i == LTC_MODE_NIBBLE;
  assign mux_enc = encode_en_i && mode_i != LTC_MODE_NIBBLE;
  ////////////////////////
  // a parked word may not move until it is popped
  property held(int p);
    word_valid_o[p] && !word_ready_i[p] |=> word_valid_o[p] &&
      $stable(word_lo_o[p]) && $stable(word_hi_o[p]);
  endproperty
  a_reset_empty: assert property (disable iff (1'b0)
    rst_i |=> word_valid_o == '0) else $error("valid during reset");
  a_hold_cd: assert property (held(0)) else $error("c/d word moved");
  a_hold_ef: assert property (held(1)) else $error("e/f word moved");
  a_hold_gh: assert property (held(2)) else $error("g/h word moved");
  a_byte_top_zero: assert property (mux_enc && word_valid_o[0] |->
    word_lo_o[0][9:8] == 2'h0 && word_hi_o[0][9:8] == 2'h0)
    else $error("byte word top bits set");
  a_nib_top_zero: assert property (nib_enc && word_valid_o[1] |->
    word_lo_o[1][9:8] == 2'h0 && word_hi_o[1][9:8] == 2'h0)
    else $error("nibble word top bits set");
  a_nib_klo_bit: assert property (nib_enc && word_valid_o[2] |->
    k_lo_o[2] == word_lo_o[2][7]) else $error("lower k flag wrong");
  a_nib_khi_bit: assert property (nib_enc && word_valid_o[0] |->
    k_hi_o[0] == word_hi_o[0][7]) else $error("upper k flag wrong");
  c_pop: cover property (word_valid_o[0] && word_ready_i[0]);
  c_nib: cover property (nib_enc && word_valid_o == 3'h7);
  c_kflag: cover property (mux_enc && k_hi_o[1]);
endmodule
bind ltc_capture ltc_capture_chk #(.NP(NP)) u_chk (.*);

/* File: dv/ltc_lane_src.sv */
// ltc_lane_src: protocol device driving the ddr transmit lanes.
// assumes: clocks park high between frames; 160 ns lane period.
`timescale 1ns/1ps
module ltc_lane_src (
  input wire logic indep_i,
  input wire logic enc_i,
  output logic sclk_o,
  output logic [2:0] pclk_o,
  output logic [2:0][9:0] lane_o
);
  // parked state
  initial begin
    sclk_o = 1'b1;
    pclk_o = 3'h7;
    lane_o = '0;
  end
  // data first, edge near mid-half; off the 5 ns grid on purpose
  task automatic half(input logic [2:0][9:0] v, input logic lv);
    logic [2:0][9:0] w;
    w = v;
    for (int p = 0; p < 3; p++) begin
      if (enc_i) w[p][9] = 1'b0; // bit 9 unused while encoding
    end
    lane_o = w;
    #37.3;
    if (indep_i) pclk_o = {3{lv}}; // own clock per pair
    else sclk_o = lv; // shared clock, all pairs
    #42.7;
  endtask
  // lower channel or low nibble on the fall
  task automatic frame(input logic [2:0][9:0] f, input logic [2:0][9:0] r);
    half(f, 1'b0);
    half(r, 1'b1);
  endtask
  // hold time over: lanes no longer show the last value
  task automatic idle();
    lane_o = ~lane_o;
  endtask
endmodule

/* File: dv/testbench.sv */
// testbench: lane capture with a lane source model.
// assumes: one reset per strap setting, lane clocks stop between bursts.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  err_count++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
  import ltc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  ltc_mode_t mode_i = LTC_MODE_MUX;
  logic encode_en_i = 1'b0;
  logic [2:0] word_ready_i = 3'h0;
  logic [2:0] word_valid_o, capture_ready_o, k_lo_o, k_hi_o;
  logic [2:0][9:0] word_lo_o, word_hi_o, fv[5], rv[5];
  wire sclk;
  wire [2:0] pclk;
  wire [2:0][9:0] ln;
  int err_count = 0;
  int checks_done = 0;
  ////////////////////////
  always #2.5 clk_sys_i = ~clk_sys_i;
  ltc_lane_src u_ltc_lane_src (.indep_i(mode_i == LTC_MODE_INDEP),
    .enc_i(encode_en_i), .sclk_o(sclk), .pclk_o(pclk), .lane_o(ln));
  ltc_capture u_ltc_capture (.shared_tx_clock_i(sclk),
    .tx_clock_pair_cd_i(pclk[0]), .tx_clock_pair_ef_i(pclk[1]),
    .tx_clock_pair_gh_i(pclk[2]), .tx_lane_cd_i(ln[0][7:0]),
    .tx_lane_cd_bit8_kflag_i(ln[0][8]), .tx_lane_cd_bit9_i(ln[0][9]),
    .tx_lane_ef_i(ln[1][7:0]), .tx_lane_ef_bit8_kflag_i(ln[1][8]),
    .tx_lane_ef_bit9_i(ln[1][9]), .tx_lane_gh_i(ln[2][7:0]),
    .tx_lane_gh_bit8_kflag_i(ln[2][8]), .tx_lane_gh_bit9_i(ln[2][9]), .*);
  ////////////////////////
  // expected {k_hi, hi, k_lo, lo} for one falling/rising pair
  function automatic logic [21:0] exp_w(ltc_mode_t m, logic e,
                                        logic [9:0] f, logic [9:0] r);
    logic [9:0] lo, hi;
    logic kl, kh;
    {lo, hi, kl, kh} = {f, r, 2'h0};
    if (m == LTC_MODE_NIBBLE && !e) begin
      lo = {r[4:0], f[4:0]};
      hi = {r[9:5], f[9:5]};
    end else if (m == LTC_MODE_NIBBLE) begin
      {hi, kh} = {2'h0, r[8:5], f[8:5], r[8]};
      {lo, kl} = {2'h0, r[3:0], f[3:0], r[3]};
    end else if (e) begin
      {lo, hi, kl, kh} = {2'h0, f[7:0], 2'h0, r[7:0], f[8], r[8]};
    end
    return {kh, hi, kl, lo};
  endfunction
  // strap and reset with lane clocks running, then n pairs, then drain
  task automatic run(ltc_mode_t m, logic e, int n, int s);
    logic [21:0] g;
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    mode_i <= m;
    encode_en_i <= e;
    // lane reset takes four lane edges to set and four to clear
    repeat (6) u_ltc_lane_src.frame(fv[0], rv[0]);
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) u_ltc_lane_src.frame(fv[0], rv[0]);
    for (int i = 0; i < n; i++) begin
      for (int p = 0; p < 3; p++) begin
        fv[i][p] = 10'(37 * i + 101 * p + s);
        rv[i][p] = 10'(~(59 * i + 13 * p + s));
      end
      u_ltc_lane_src.frame(fv[i], rv[i]);
    end
    u_ltc_lane_src.idle();
    if (n > FIFO_DEPTH) `CHK(capture_ready_o, 3'h0);
    for (int i = 0; i < n && i < FIFO_DEPTH; i++) begin
      for (int t = 0; t < 200 && word_valid_o !== 3'h7; t++) begin
        @(posedge clk_sys_i);
        #1;
      end
      `CHK(word_valid_o, 3'h7);
      for (int p = 0; p < 3; p++) begin
        g = {k_hi_o[p], word_hi_o[p], k_lo_o[p], word_lo_o[p]};
        `CHK(g, exp_w(m, e, fv[i][p], rv[i][p]));
      end
      @(posedge clk_sys_i);
      word_ready_i <= 3'h7;
      @(posedge clk_sys_i);
      word_ready_i <= 3'h0;
      #1;
    end
    repeat (4) @(posedge clk_sys_i);
    #1;
    `CHK(word_valid_o, 3'h0);
  endtask
  ////////////////////////
  // raw words, five into a four-deep fifo: the last is refused
  task automatic s_mux_raw();
    run(LTC_MODE_MUX, 1'b0, 5, 3);
  endtask
  // bytes with k flags on bit 8
  task automatic s_mux_enc();
    run(LTC_MODE_MUX, 1'b1, 3, 200);
  endtask
  // nibble split with bit 8 giving word bits 3 and 8
  task automatic s_nib_raw();
    run(LTC_MODE_NIBBLE, 1'b0, 3, 77);
  endtask
  // nibble split with both k flags
  task automatic s_nib_enc();
    run(LTC_MODE_NIBBLE, 1'b1, 4, 9);
  endtask
  // pair clocks only; the shared clock stays parked
  task automatic s_indep();
    run(LTC_MODE_INDEP, 1'b0, 2, 500);
  endtask
  // verdict
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // whole run is near 11 us; a hang stops well after that
  initial begin
    #60000;
    err_count++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    s_mux_raw();
    s_mux_enc();
    s_nib_raw();
    s_nib_enc();
    s_indep();
    results();
  end
endmodule
